//--- rtl/rcg_regs.svh
`ifndef RCG_REGS_SVH
`define RCG_REGS_SVH

// command codes and register offsets on the serial port
`define RCG_OFS_GROUP_SNAPSHOT  8'h1E
`define RCG_OFS_RANGE_SELECT    8'h1D

// channel range register layout
`define RCG_RANGE_RESET         16'h0000
`define RCG_SNS_LSB_CH1         14
`define RCG_BUS_LSB_CH1         6
`define RCG_FIELD_STEP          2

// widths of the readable results
`define RCG_CHANNELS            4
`define RCG_MEAS_W              16
`define RCG_POWER_W             30
`define RCG_ACCUM_W             48
`define RCG_COUNT_W             24
`define RCG_SETTLE_W            18

// settle time before refreshed results may be read
`define RCG_SETTLE_TIME_US      1000
`define RCG_CLK_FREQ_MHZ        250
`define RCG_SETTLE_CYCLES       (`RCG_SETTLE_TIME_US * `RCG_CLK_FREQ_MHZ)

`endif

//--- rtl/rcg_pkg.sv
`default_nettype none

`include "rcg_regs.svh"

package rcg_pkg;

    // sense-voltage full-scale selector
    typedef enum logic [1:0] {
        RCG_SNS_UNI100 = 2'h0,
        RCG_SNS_BI100  = 2'h1,
        RCG_SNS_BI50   = 2'h2,
        RCG_SNS_RSVD   = 2'h3
    } rcg_sense_range_t;

    // rail-voltage full-scale selector
    typedef enum logic [1:0] {
        RCG_BUS_UNI32 = 2'h0,
        RCG_BUS_BI32  = 2'h1,
        RCG_BUS_BI16  = 2'h2,
        RCG_BUS_RSVD  = 2'h3
    } rcg_bus_range_t;

    typedef logic [`RCG_CHANNELS-1:0][`RCG_MEAS_W-1:0]  rcg_meas_arr_t;
    typedef logic [`RCG_CHANNELS-1:0][`RCG_POWER_W-1:0] rcg_power_arr_t;
    typedef logic [`RCG_CHANNELS-1:0][`RCG_ACCUM_W-1:0] rcg_accum_arr_t;

    // state of the accumulator bank
    typedef struct packed {
        rcg_accum_arr_t          accum;
        logic [`RCG_COUNT_W-1:0] count;
    } rcg_acc_state_t;

    // state of the range and snapshot block
    typedef struct packed {
        logic [15:0]              range_select;
        rcg_meas_arr_t            snap_rail;
        rcg_meas_arr_t            snap_shunt;
        rcg_accum_arr_t           snap_accum;
        logic [`RCG_COUNT_W-1:0]  snap_count;
        logic [`RCG_SETTLE_W-1:0] settle_cnt;
        logic                     done;
    } rcg_state_t;

endpackage

`default_nettype wire

//--- rtl/rcg_accum_bank.sv
`default_nettype none

`include "rcg_regs.svh"

module rcg_accum_bank (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    sample_valid,
    input  wire rcg_pkg::rcg_power_arr_t sample_power,
    input  wire logic                    clear,
    output rcg_pkg::rcg_accum_arr_t      accum,
    output logic [`RCG_COUNT_W-1:0]      count
);
    import rcg_pkg::*;

    rcg_acc_state_t s_reg;
    rcg_acc_state_t s_next;

    // a sample landing on the clear cycle opens the new window, so none is lost
    always_comb begin
        s_next = s_reg;
        for (int ch = 0; ch < `RCG_CHANNELS; ch++) begin
            if (clear) begin
                s_next.accum[ch] = sample_valid ? `RCG_ACCUM_W'(sample_power[ch]) : '0;
            end else if (sample_valid) begin
                s_next.accum[ch] = s_reg.accum[ch] + `RCG_ACCUM_W'(sample_power[ch]);
            end
        end
        if (clear) begin
            s_next.count = sample_valid ? `RCG_COUNT_W'(1) : '0;
        end else if (sample_valid) begin
            s_next.count = s_reg.count + `RCG_COUNT_W'(1);
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign accum = s_reg.accum;
    assign count = s_reg.count;

endmodule

`default_nettype wire

//--- rtl/rcg_range_snapshot.sv
// Summary of operation
// RULE1: sense range field per channel, bits 15-14 down to 9-8: uni100, bi100, bi50.
// RULE2: two-bit rail range selector per channel, channel one bits 7-6, channel four 1-0.
// RULE3: rail selector 00 means unipolar 32 V to 0 V, the reset setting.
// RULE4: rail selector 01 means bipolar plus/minus 32 V.
// RULE5: rail selector 10 means bipolar plus/minus 16 V.
// RULE6: host never writes 11 into a rail selector; that code is reserved.
// RULE7: group snapshot code 1EH is a send byte with no data bytes.
// RULE8: group snapshot executes when it arrives through the general call address.
// RULE9: snapshot copies accumulators, count, rail and sense results into readable registers.
// RULE10: group snapshot clears internal accumulators and count like the plain snapshot.
// RULE11: host waits at least 1 ms after the snapshot before reading results.
// RULE12: readable results hold until the next snapshot of any kind.
`default_nettype none

`include "rcg_regs.svh"

module rcg_range_snapshot #(
    parameter int SETTLE_CYCLES = `RCG_SETTLE_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     cmd_valid,
    input  wire logic [7:0]               cmd_code,
    input  wire logic                     cmd_no_data,
    input  wire logic                     cmd_general_call,
    input  wire logic                     wr_valid,
    input  wire logic [7:0]               wr_addr,
    input  wire logic [15:0]              wr_data,
    input  wire logic                     other_snapshot,
    input  wire logic                     other_keep_accum,
    input  wire rcg_pkg::rcg_meas_arr_t   live_rail,
    input  wire rcg_pkg::rcg_meas_arr_t   live_shunt,
    input  wire logic                     sample_valid,
    input  wire rcg_pkg::rcg_power_arr_t  sample_power,
    output logic [15:0]                   range_select,
    output rcg_pkg::rcg_sense_range_t     sense_range_ch1,
    output rcg_pkg::rcg_sense_range_t     sense_range_ch2,
    output rcg_pkg::rcg_sense_range_t     sense_range_ch3,
    output rcg_pkg::rcg_sense_range_t     sense_range_ch4,
    output rcg_pkg::rcg_bus_range_t       bus_range_ch1,
    output rcg_pkg::rcg_bus_range_t       bus_range_ch2,
    output rcg_pkg::rcg_bus_range_t       bus_range_ch3,
    output rcg_pkg::rcg_bus_range_t       bus_range_ch4,
    output logic [3:0]                    sense_bipolar,
    output logic [3:0]                    sense_half_scale,
    output logic [3:0]                    bus_bipolar,
    output logic [3:0]                    bus_half_scale,
    output rcg_pkg::rcg_meas_arr_t        snap_rail,
    output rcg_pkg::rcg_meas_arr_t        snap_shunt,
    output rcg_pkg::rcg_accum_arr_t       snap_accum,
    output logic [`RCG_COUNT_W-1:0]       snap_count,
    output logic                          group_snapshot_done,
    output logic                          settling
);
    import rcg_pkg::*;

    rcg_state_t               s_reg;
    rcg_state_t               s_next;
    logic                     grp_cmd;
    logic                     snap_go;
    logic                     acc_clear;
    rcg_accum_arr_t           acc_live;
    logic [`RCG_COUNT_W-1:0]  acc_count;

    // field of channel ch (0 = channel one) starting at the channel-one lsb
    function automatic logic [1:0] field_of(input logic [15:0] r, input int lsb1, input int ch);
        int lsb;
        lsb = lsb1 - `RCG_FIELD_STEP * ch;
        return r[lsb +: 2];
    endfunction

    // only a data-less send byte of 1EH counts; general call or own address both execute
    assign grp_cmd   = cmd_valid && (cmd_code == `RCG_OFS_GROUP_SNAPSHOT) && cmd_no_data; // RULE7 RULE8
    assign snap_go   = grp_cmd || other_snapshot;
    // the accumulator-preserving flavour is the only snapshot that leaves the sums alone
    assign acc_clear = grp_cmd || (other_snapshot && !other_keep_accum); // RULE10

    rcg_accum_bank rcg_accum_bank_inst (
        .clk          (clk),
        .rstn         (rstn),
        .sample_valid (sample_valid),
        .sample_power (sample_power),
        .clear        (acc_clear),
        .accum        (acc_live),
        .count        (acc_count)
    );

    // next state: range writes, snapshot copy, settle countdown
    always_comb begin
        s_next      = s_reg;
        s_next.done = grp_cmd;
        if (wr_valid && (wr_addr == `RCG_OFS_RANGE_SELECT)) begin
            s_next.range_select = wr_data; // RULE2 RULE6
        end
        if (snap_go) begin
            s_next.snap_rail  = live_rail; // RULE9
            s_next.snap_shunt = live_shunt;
            s_next.snap_accum = acc_live;
            s_next.snap_count = acc_count;
            s_next.settle_cnt = `RCG_SETTLE_W'(SETTLE_CYCLES); // RULE11
        end else if (s_reg.settle_cnt != '0) begin
            s_next.settle_cnt = s_reg.settle_cnt - `RCG_SETTLE_W'(1);
        end
    end

    // state register; the range selectors come up unipolar
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_reg              <= '0;
            s_reg.range_select <= `RCG_RANGE_RESET; // RULE3
        end else begin
            s_reg <= s_next; // RULE12
        end
    end

    assign range_select        = s_reg.range_select;
    assign snap_rail           = s_reg.snap_rail;
    assign snap_shunt          = s_reg.snap_shunt;
    assign snap_accum          = s_reg.snap_accum;
    assign snap_count          = s_reg.snap_count;
    assign group_snapshot_done = s_reg.done;
    // a limitation: results are stable at once, the flag only mirrors the host's wait
    assign settling            = (s_reg.settle_cnt != '0);

    // field split of the range register
    assign sense_range_ch1 = rcg_sense_range_t'(field_of(s_reg.range_select, `RCG_SNS_LSB_CH1, 0)); // RULE1
    assign sense_range_ch2 = rcg_sense_range_t'(field_of(s_reg.range_select, `RCG_SNS_LSB_CH1, 1));
    assign sense_range_ch3 = rcg_sense_range_t'(field_of(s_reg.range_select, `RCG_SNS_LSB_CH1, 2));
    assign sense_range_ch4 = rcg_sense_range_t'(field_of(s_reg.range_select, `RCG_SNS_LSB_CH1, 3));
    assign bus_range_ch1   = rcg_bus_range_t'(field_of(s_reg.range_select, `RCG_BUS_LSB_CH1, 0)); // RULE2
    assign bus_range_ch2   = rcg_bus_range_t'(field_of(s_reg.range_select, `RCG_BUS_LSB_CH1, 1));
    assign bus_range_ch3   = rcg_bus_range_t'(field_of(s_reg.range_select, `RCG_BUS_LSB_CH1, 2));
    assign bus_range_ch4   = rcg_bus_range_t'(field_of(s_reg.range_select, `RCG_BUS_LSB_CH1, 3));

    // decoded scale controls for the converters; reserved codes fall back to unipolar full scale
    always_comb begin
        for (int ch = 0; ch < `RCG_CHANNELS; ch++) begin
            unique case (rcg_sense_range_t'(field_of(s_reg.range_select, `RCG_SNS_LSB_CH1, ch)))
                RCG_SNS_BI100: begin
                    sense_bipolar[ch]    = 1'b1; // RULE1
                    sense_half_scale[ch] = 1'b0;
                end
                RCG_SNS_BI50: begin
                    sense_bipolar[ch]    = 1'b1;
                    sense_half_scale[ch] = 1'b1;
                end
                RCG_SNS_UNI100, RCG_SNS_RSVD: begin
                    sense_bipolar[ch]    = 1'b0;
                    sense_half_scale[ch] = 1'b0;
                end
            endcase
            unique case (rcg_bus_range_t'(field_of(s_reg.range_select, `RCG_BUS_LSB_CH1, ch)))
                RCG_BUS_BI32: begin
                    bus_bipolar[ch]    = 1'b1; // RULE4
                    bus_half_scale[ch] = 1'b0;
                end
                RCG_BUS_BI16: begin
                    bus_bipolar[ch]    = 1'b1; // RULE5
                    bus_half_scale[ch] = 1'b1;
                end
                RCG_BUS_UNI32, RCG_BUS_RSVD: begin
                    bus_bipolar[ch]    = 1'b0; // RULE3 RULE6
                    bus_half_scale[ch] = 1'b0;
                end
            endcase
        end
    end

    // checks beside the logic they guard
    chk_range_reset_zero: assert property (@(posedge clk) !rstn |=> range_select == `RCG_RANGE_RESET && !bus_bipolar[0]) // RULE3
        else $error("range register not cleared by reset");

    chk_range_write_lands: assert property (@(posedge clk) disable iff (!rstn)
        wr_valid && (wr_addr == `RCG_OFS_RANGE_SELECT)
        |=> range_select == $past(wr_data) && bus_range_ch4 == $past(wr_data[1:0])) // RULE2
        else $error("range write did not reach the channel fields");

    chk_sense_field_map: assert property (@(posedge clk) disable iff (!rstn)
        wr_valid && (wr_addr == `RCG_OFS_RANGE_SELECT) && (wr_data[15:14] == 2'h2)
        |=> sense_bipolar[0] && sense_half_scale[0] && sense_range_ch1 == RCG_SNS_BI50) // RULE1
        else $error("channel one sense range decode wrong");

    chk_bus_bi32_decode: assert property (@(posedge clk) disable iff (!rstn)
        bus_range_ch1 == RCG_BUS_BI32 |-> bus_bipolar[0] && !bus_half_scale[0] && range_select[7:6] == 2'h1) // RULE4
        else $error("channel one 32 V bipolar decode wrong");

    chk_bus_bi16_decode: assert property (@(posedge clk) disable iff (!rstn)
        range_select[1:0] == 2'h2 |-> bus_bipolar[3] && bus_half_scale[3]) // RULE5
        else $error("channel four 16 V bipolar decode wrong");

    chk_data_cmd_ignored: assert property (@(posedge clk) disable iff (!rstn)
        cmd_valid && (cmd_code == `RCG_OFS_GROUP_SNAPSHOT) && !cmd_no_data && !other_snapshot
        |=> !group_snapshot_done && $stable(snap_rail)) // RULE7
        else $error("group snapshot with data bytes was executed");

    chk_general_call_copy: assert property (@(posedge clk) disable iff (!rstn)
        cmd_valid && cmd_general_call && (cmd_code == `RCG_OFS_GROUP_SNAPSHOT) && cmd_no_data
        |=> group_snapshot_done && snap_rail == $past(live_rail)
            && snap_shunt == $past(live_shunt) && snap_count == $past(acc_count)) // RULE8 RULE9
        else $error("general call snapshot did not copy results");

    chk_accum_cleared: assert property (@(posedge clk) disable iff (!rstn)
        grp_cmd |=> acc_count == ($past(sample_valid) ? `RCG_COUNT_W'(1) : `RCG_COUNT_W'(0))) // RULE10
        else $error("group snapshot did not clear accumulation count");

    chk_settle_flag: assert property (@(posedge clk) disable iff (!rstn)
        snap_go |=> settling && s_reg.settle_cnt == `RCG_SETTLE_W'(SETTLE_CYCLES)) // RULE11
        else $error("settle window not started by snapshot");

    chk_results_hold: assert property (@(posedge clk) disable iff (!rstn)
        !snap_go |=> $stable(snap_rail) && $stable(snap_accum) && $stable(snap_count)) // RULE12
        else $error("readable results changed without a snapshot");

endmodule

`default_nettype wire

//--- verif/rcg_host_model.sv
`default_nettype none

// host controller behind the serial engine, seen as decoded command and write strobes
module rcg_host_model (
    input  wire logic   clk,
    input  wire logic   settling,
    output logic        cmd_valid,
    output logic [7:0]  cmd_code,
    output logic        cmd_no_data,
    output logic        cmd_general_call,
    output logic        wr_valid,
    output logic [7:0]  wr_addr,
    output logic [15:0] wr_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_no_data = 1'b0;
        cmd_general_call = 1'b0;
        wr_valid = 1'b0;
        wr_addr = 8'h00;
        wr_data = 16'h0000;
    end

    // one register write; the host never puts the reserved code into a rail field
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        for (int f = 0; f < 4; f++) begin
            if (data[2*f +: 2] == 2'h3) data[2*f +: 2] = 2'h0;
        end
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_addr  <= addr;
        wr_data  <= data;
        @(posedge clk);
        wr_valid <= 1'b0;
        wr_data  <= ~data; // released bus must not keep the old word
    endtask

    // send byte or longer transfer carrying a command code
    task automatic send_cmd(input logic [7:0] code, input logic no_data, input logic gcall);
        @(posedge clk);
        cmd_valid        <= 1'b1;
        cmd_code         <= code;
        cmd_no_data      <= no_data;
        cmd_general_call <= gcall;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code  <= ~code;
    endtask

    // results are read only once the settle time after a snapshot has run out
    task automatic wait_settle(output logic ok);
        int n;
        n = 0;
        while (settling !== 1'b0 && n < 64) begin
            @(posedge clk);
            n++;
        end
        ok = (settling === 1'b0);
    endtask
endmodule

`default_nettype wire

//--- verif/rcg_range_snapshot_test.sv
`default_nettype none

module rcg_range_snapshot_test;
    timeunit 1ns;
    timeprecision 100ps;
    import rcg_pkg::*;

    logic clk = 1'b0, rstn = 1'b0, other_snapshot = 1'b0, other_keep_accum = 1'b0, sample_valid = 1'b0;
    logic cmd_valid, cmd_no_data, cmd_general_call, wr_valid, done, settling, ok;
    logic [7:0]  cmd_code, wr_addr;
    logic [15:0] wr_data, range_select, d;
    logic [3:0]  sense_bipolar, sense_half_scale, bus_bipolar, bus_half_scale;
    logic [23:0] snap_count;
    rcg_meas_arr_t    live_rail, live_shunt, snap_rail, snap_shunt;
    rcg_power_arr_t   sample_power = '0;
    rcg_accum_arr_t   snap_accum;
    rcg_sense_range_t sr1, sr2, sr3, sr4;
    rcg_bus_range_t   br1, br2, br3, br4;
    int bad_count = 0;
    int checks_done = 0;

    // 250 MHz
    always #2 clk = ~clk;

    rcg_host_model host_inst (.clk(clk), .settling(settling), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_no_data(cmd_no_data), .cmd_general_call(cmd_general_call), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data));

    // short settle count keeps the run brief
    rcg_range_snapshot #(.SETTLE_CYCLES(16)) rcg_range_snapshot_inst (.clk(clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_no_data(cmd_no_data),
        .cmd_general_call(cmd_general_call), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .other_snapshot(other_snapshot), .other_keep_accum(other_keep_accum), .live_rail(live_rail),
        .live_shunt(live_shunt), .sample_valid(sample_valid), .sample_power(sample_power),
        .range_select(range_select), .sense_range_ch1(sr1), .sense_range_ch2(sr2), .sense_range_ch3(sr3),
        .sense_range_ch4(sr4), .bus_range_ch1(br1), .bus_range_ch2(br2), .bus_range_ch3(br3),
        .bus_range_ch4(br4), .sense_bipolar(sense_bipolar), .sense_half_scale(sense_half_scale),
        .bus_bipolar(bus_bipolar), .bus_half_scale(bus_half_scale), .snap_rail(snap_rail),
        .snap_shunt(snap_shunt), .snap_accum(snap_accum), .snap_count(snap_count),
        .group_snapshot_done(done), .settling(settling));

    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one power sample, channel n gets p plus n
    task automatic add_sample(input logic [29:0] p);
        @(posedge clk);
        sample_valid <= 1'b1;
        for (int ch = 0; ch < 4; ch++) sample_power[ch] <= p + 30'(ch);
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask

    task automatic other_snap(input logic keep);
        @(posedge clk);
        other_snapshot   <= 1'b1;
        other_keep_accum <= keep;
        @(posedge clk);
        other_snapshot <= 1'b0;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard, far beyond the fewer than one hundred cycles the sequence needs
    initial begin
        #(5000 * 4);
        bad_count++;
        finish_test;
    end

    initial begin
        for (int ch = 0; ch < 4; ch++) live_rail[ch] = 16'(16'h1111 * (ch + 1));
        for (int ch = 0; ch < 4; ch++) live_shunt[ch] = 16'(16'h0101 * (ch + 1));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        cmp(range_select, 48'h0);
        cmp({br1, br2, br3, br4}, 48'h0);
        cmp(bus_bipolar | bus_half_scale, 48'h0);
        // every defined code in every channel's two fields
        for (int c = 0; c < 3; c++) begin
            for (int ch = 0; ch < 4; ch++) begin
                d = (16'(c) << (14 - 2 * ch)) | (16'(c) << (6 - 2 * ch));
                host_inst.write_reg(8'h1D, d);
                #1;
                cmp(range_select, 48'(d));
                cmp({sr1, sr2, sr3, sr4}, 48'(d[15:8]));
                cmp({br1, br2, br3, br4}, 48'(d[7:0]));
                cmp({sense_bipolar[ch], sense_half_scale[ch]}, {c != 0, c == 2});
                cmp({bus_bipolar[ch], bus_half_scale[ch]}, {c != 0, c == 2});
            end
        end
        // a write to another offset leaves the range word alone
        host_inst.write_reg(8'h1C, 16'hFFFF);
        #1;
        cmp(range_select, 48'(d));
        for (int i = 1; i <= 3; i++) add_sample(30'(i * 100));
        host_inst.send_cmd(8'h1E, 1'b1, 1'b1);
        #1;
        cmp(done, 1'b1);
        cmp(settling, 1'b1);
        cmp(snap_count, 48'h3);
        for (int ch = 0; ch < 4; ch++) begin
            cmp(snap_rail[ch], 48'(16'h1111 * (ch + 1)));
            cmp(snap_shunt[ch], 48'(16'h0101 * (ch + 1)));
            cmp(snap_accum[ch], 48'(600 + 3 * ch));
        end
        @(posedge clk);
        #1;
        cmp(done, 1'b0);
        // new live value changes on an edge, after the snapshot has been taken
        @(posedge clk);
        live_rail[0] <= 16'hBEEF;
        add_sample(30'h10);
        host_inst.wait_settle(ok);
        cmp(ok, 1'b1);
        cmp(snap_rail[0], 48'h1111);
        // the code with data bytes attached is not a snapshot
        host_inst.send_cmd(8'h1E, 1'b0, 1'b1);
        #1;
        cmp(done, 1'b0);
        cmp(snap_count, 48'h3);
        other_snap(1'b1);
        #1;
        cmp(snap_rail[0], 48'hBEEF);
        cmp(snap_count, 48'h1);
        // own address, accumulators were kept by the preserving snapshot
        host_inst.send_cmd(8'h1E, 1'b1, 1'b0);
        #1;
        cmp(done, 1'b1);
        cmp(snap_accum[1], 48'h11);
        host_inst.send_cmd(8'h1E, 1'b1, 1'b1);
        #1;
        cmp(snap_count, 48'h0);
        cmp(snap_accum[2], 48'h0);
        finish_test;
    end
endmodule

`default_nettype wire
